// ===== pkg/vic_pkg.sv
package vic_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] INT_EN_ADDR = 8'ha8;
  localparam logic [7:0] INT_EN_RESET = 8'h00;
  localparam int GATE_BIT = 7;
  localparam int SPI0_MASK_BIT = 6;
  localparam int TIMER2_MASK_BIT = 5;
  localparam int UART_MASK_BIT = 4;
  localparam int TIMER1_MASK_BIT = 3;
  localparam int EXT1_MASK_BIT = 2;
  localparam int TIMER0_MASK_BIT = 1;
  localparam int EXT0_MASK_BIT = 0;

  // ****************************************************************
  // Sources and vectors
  // ****************************************************************
  localparam int NUM_SRC = 19;
  localparam int SRC_W = 5;
  localparam int NUM_EXT_SRC = 12;
  localparam int NUM_AUTO_CLR = 4;
  localparam logic [SRC_W-1:0] SRC_SUPPLY = 5'h0f;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_LAST = 16'h0093;

  // ****************************************************************
  // Timing in system clocks (40 MHz, 25 ns)
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int DETECT_CYC = 1;
  localparam int SINGLE_INSTR_CYC = 1;
  localparam int CALL_CYC = 5;
  localparam int RETURN_CYC = 5;
  localparam int DIVIDE_CYC = 8;
  localparam int MIN_RESP_CYC = DETECT_CYC + SINGLE_INSTR_CYC + CALL_CYC;
  localparam int MAX_RESP_CYC = DETECT_CYC + RETURN_CYC + DIVIDE_CYC + CALL_CYC;
  localparam logic [2:0] CALL_CNT_LOAD = 3'(CALL_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_CALL
  } vic_state_t;

endpackage

// ===== hdl/vic_prio_enc.sv
`timescale 1ns/1ps
module vic_prio_enc #(
  parameter int N = 19,
  parameter int W = 5
) (
  input wire logic [N-1:0] req_i,
  output logic any_o,
  output logic [W-1:0] idx_o
);

  // Lowest index wins; scanning downward leaves the lowest set bit
  always_comb begin
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = W'(i);
      end
    end
  end

  assign any_o = |req_i;

endmodule

// ===== hdl/vic_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Flags are sampled and priority decoded every clock, not at instruction ends.
// - Request registered one clock after detection; core adds instruction and 5-clock call.
// - After a return, one more instruction completes before the next request.
// - Worst response 19 clocks: detect, return, divide, call.
// - Equal or higher level in service holds a new request pending.
// - Vectors start at 0x0003 and step by 8 per arbitration order.
// - External 0/1 and timer 0/1 flags get a clear pulse on vectoring.
// - Enable bit 7 gates every source; when set, each mask applies.
// - Enable register at 0xa8 on every page, bit-writable, resets to zero.
// - Timer 2 mask passes low or high overflow flag; software clears both.
// - SPI port 0 mask gates OR of its four flags.
// - Enable bits 2 and 0 mask external inputs 1 and 0.
// - Enable bits 3 and 1 mask timer 1 and timer 0 overflows.
// - Enable bit 4 masks UART rx/tx done OR; no hardware clear.
// - Read-only flags like supply warning stop only through their enable.
// - High level preempts low routine; high routine is never preempted.
// - Higher level wins; equal levels resolved by lower arbitration order.
// - Flags pend regardless of enables and are serviced once enabled.
// - Flag still set after return raises a new request after one instruction.
module vic_ctrl
  import vic_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic bit_wr_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_val_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  input wire logic ext_irq_pin0_flag_i,
  input wire logic ext_irq_pin1_flag_i,
  input wire logic timer0_overflow_flag_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic uart_rx_done_flag_i,
  input wire logic uart_tx_done_flag_i,
  input wire logic timer2_low_overflow_flag_i,
  input wire logic timer2_high_overflow_flag_i,
  input wire logic spi_transfer_done_flag_i,
  input wire logic spi_write_collision_flag_i,
  input wire logic spi_mode_fault_flag_i,
  input wire logic spi_rx_overrun_flag_i,
  input wire logic [NUM_EXT_SRC-1:0] ext_src_flags_i,
  input wire logic [NUM_EXT_SRC-1:0] ext_src_enable_i,
  input wire logic [NUM_SRC-1:0] src_high_prio_i,
  input wire logic irq_ack_i,
  input wire logic return_done_i,
  input wire logic instr_done_i,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  output logic [NUM_AUTO_CLR-1:0] flag_clear_o,
  output logic [1:0] in_service_o
);

  // ****************************************************************
  // Enable register
  // ****************************************************************
  logic [7:0] int_en_q;
  logic [7:0] int_en_d;
  logic [7:0] int_en_bit_upd;
  logic [7:0] sfr_rdata_q;
  wire byte_hit = sfr_addr_i == INT_EN_ADDR;
  wire bit_hit = bit_addr_i[7:3] == INT_EN_ADDR[7:3];
  wire [2:0] bit_pos = bit_addr_i[2:0];

  // No page input: the register decodes the same on every page
  always_comb begin
    int_en_bit_upd = int_en_q;
    int_en_bit_upd[bit_pos] = bit_val_i;
  end

  assign int_en_d = (sfr_wr_i && byte_hit) ? sfr_wdata_i :
                    (bit_wr_i && bit_hit) ? int_en_bit_upd : int_en_q;
  assign sfr_hit_o = byte_hit;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_en_q <= INT_EN_RESET;
      sfr_rdata_q <= 8'h00;
    end else if (clk_en_i) begin
      int_en_q <= int_en_d;
      sfr_rdata_q <= (sfr_rd_i && byte_hit) ? int_en_q : 8'h00;
    end
  end

  assign sfr_rdata_o = sfr_rdata_q;

  // ****************************************************************
  // Source gating
  // ****************************************************************
  wire uart_any = uart_rx_done_flag_i | uart_tx_done_flag_i;
  wire timer2_any = timer2_low_overflow_flag_i | timer2_high_overflow_flag_i;
  wire spi0_any = spi_transfer_done_flag_i | spi_write_collision_flag_i |
                  spi_mode_fault_flag_i | spi_rx_overrun_flag_i;
  // Order is the arbitration order; enable bits 0..6 line up with it
  wire [NUM_SRC-1:0] pend = {ext_src_flags_i, spi0_any, timer2_any, uart_any,
                             timer1_overflow_flag_i, ext_irq_pin1_flag_i,
                             timer0_overflow_flag_i, ext_irq_pin0_flag_i};
  // Read-only flags such as the supply warning only drop out through their mask
  wire [NUM_SRC-1:0] mask = {ext_src_enable_i, int_en_q[6:0]};
  wire gate = int_en_q[GATE_BIT];
  wire [NUM_SRC-1:0] elig = pend & mask & {NUM_SRC{gate}};
  wire [NUM_SRC-1:0] elig_hi = elig & src_high_prio_i;
  wire [NUM_SRC-1:0] elig_lo = elig & ~src_high_prio_i;

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  logic hi_any;
  logic lo_any;
  logic [SRC_W-1:0] hi_idx;
  logic [SRC_W-1:0] lo_idx;

  vic_prio_enc #(.N(NUM_SRC), .W(SRC_W)) u_enc_hi (
    .req_i(elig_hi),
    .any_o(hi_any),
    .idx_o(hi_idx)
  );

  vic_prio_enc #(.N(NUM_SRC), .W(SRC_W)) u_enc_lo (
    .req_i(elig_lo),
    .any_o(lo_any),
    .idx_o(lo_idx)
  );

  wire win_valid = hi_any | lo_any;
  wire win_hi = hi_any;
  wire [SRC_W-1:0] win_idx = hi_any ? hi_idx : lo_idx;
  wire [15:0] win_vec = VEC_BASE + {8'h00, win_idx, 3'b000};

  // ****************************************************************
  // Service state
  // ****************************************************************
  vic_state_t state_q;
  vic_state_t state_d;
  logic act_hi_q;
  logic act_lo_q;
  logic hold_q;
  logic lvl_q;
  logic [SRC_W-1:0] idx_q;
  logic [15:0] vec_q;
  logic [2:0] call_cnt_q;
  logic [NUM_AUTO_CLR-1:0] clr_q;

  // A high routine blocks all; a low routine admits only high requests
  wire level_ok = act_hi_q ? 1'b0 : (act_lo_q ? win_hi : 1'b1);
  wire permit = win_valid && level_ok && !hold_q;
  wire ack_take = (state_q == ST_REQ) && irq_ack_i;
  wire call_end = (state_q == ST_CALL) && (call_cnt_q == 3'd0);
  wire auto_clr = idx_q < SRC_W'(NUM_AUTO_CLR);
  wire [NUM_AUTO_CLR-1:0] clr_onehot = NUM_AUTO_CLR'(1) << idx_q[1:0];

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (permit) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (ack_take) begin
          state_d = ST_CALL;
        end else if (!permit) begin
          state_d = ST_IDLE;
        end
      end
      ST_CALL: begin
        if (call_end) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      lvl_q <= 1'b0;
      vec_q <= VEC_RESET;
    end else if (clk_en_i) begin
      state_q <= state_d;
      // Winner is re-sampled every clock until the core takes it
      if (state_d == ST_REQ && !ack_take) begin
        idx_q <= win_idx;
        lvl_q <= win_hi;
        vec_q <= win_vec;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      call_cnt_q <= 3'd0;
    end else if (clk_en_i) begin
      if (ack_take) begin
        call_cnt_q <= CALL_CNT_LOAD;
      end else if (call_cnt_q != 3'd0) begin
        call_cnt_q <= call_cnt_q - 3'd1;
      end
    end
  end

  // Only the two external and two timer flags are cleared by vectoring
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clr_q <= '0;
    end else if (clk_en_i) begin
      clr_q <= (ack_take && auto_clr) ? clr_onehot : '0;
    end
  end

  // Ack marks the level in service; return retires the highest one
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end else if (clk_en_i) begin
      if (ack_take && lvl_q) begin
        act_hi_q <= 1'b1;
      end else if (return_done_i && act_hi_q) begin
        act_hi_q <= 1'b0;
      end
      if (ack_take && !lvl_q) begin
        act_lo_q <= 1'b1;
      end else if (return_done_i && !act_hi_q) begin
        act_lo_q <= 1'b0;
      end
    end
  end

  // The return sets the hold; a coincident instruction end does not clear it
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_q <= 1'b0;
    end else if (clk_en_i) begin
      if (return_done_i) begin
        hold_q <= 1'b1;
      end else if (instr_done_i) begin
        hold_q <= 1'b0;
      end
    end
  end

  assign irq_req_o = state_q == ST_REQ;
  assign irq_vector_o = vec_q;
  assign flag_clear_o = clr_q;
  assign in_service_o = {act_hi_q, act_lo_q};

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_taken;
    irq_req_o && irq_ack_i && clk_en_i;
  endsequence

  sequence s_return;
    return_done_i && clk_en_i;
  endsequence

  AST_DETECT_ONE_CLK: assert property (
    (state_q == ST_IDLE && permit && clk_en_i) |=> irq_req_o)
    else $error("Eligible request not raised one clock after detection");

  AST_GATE_OFF: assert property (
    (!int_en_q[GATE_BIT] && state_q == ST_IDLE) |=> !irq_req_o)
    else $error("Request raised with global gate off");

  AST_CALL_SPACING: assert property (
    s_taken |=> !irq_req_o [*5])
    else $error("New request during the long call");

  AST_RETURN_HOLD: assert property (
    s_return ##1 (!instr_done_i || !clk_en_i) |=> !permit)
    else $error("Request permitted before the instruction after return");

  AST_AUTO_CLEAR: assert property (
    s_taken |=> (flag_clear_o == ($past(idx_q) < SRC_W'(NUM_AUTO_CLR) ?
                 NUM_AUTO_CLR'(1) << $past(idx_q[1:0]) : '0)))
    else $error("Wrong hardware flag clear on vectoring");

  AST_HIGH_NOT_PREEMPTED: assert property (
    act_hi_q |-> !irq_req_o)
    else $error("High level routine preempted");

  AST_LOW_ONLY_BY_HIGH: assert property (
    (act_lo_q && irq_req_o) |-> lvl_q)
    else $error("Low routine preempted by equal level");

  AST_VEC_TABLE: assert property (
    irq_req_o |-> (vec_q >= VEC_BASE && vec_q <= VEC_LAST && vec_q[2:0] == 3'h3))
    else $error("Vector outside the fixed table");

  AST_LEVEL_WINS: assert property (
    (state_q == ST_IDLE && permit && hi_any && lo_any && clk_en_i) |=> lvl_q)
    else $error("Low level won over high level");

  AST_EN_WRITE: assert property (
    (sfr_wr_i && byte_hit && clk_en_i) |=> int_en_q == $past(sfr_wdata_i))
    else $error("Enable register write lost");

  AST_LEVEL_MARK: assert property (
    s_taken |=> in_service_o[$past(lvl_q)])
    else $error("Acknowledged level not marked active");

endmodule

// ===== tb/vic_core_model.sv
`timescale 1ns/1ps
module vic_core_model #(
  parameter int INSTR_CYC = 8
) (
  input wire logic mclk_i,
  input wire logic auto_ack_i,
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vector_i,
  output logic irq_ack_o,
  output logic return_done_o,
  output logic instr_done_o,
  output logic [15:0] last_vec_o
);
  // ****
  // Core side of the call handshake
  // ****
  initial begin
    irq_ack_o = 1'b0;
    return_done_o = 1'b0;
    instr_done_o = 1'b0;
    last_vec_o = 16'h0000;
  end
  // One-cycle ack, raised off-edge so the controller sees it settled
  always @(negedge mclk_i) irq_ack_o <= irq_req_i && auto_ack_i && !irq_ack_o;
  always @(posedge mclk_i) if (irq_ack_o && irq_req_i) last_vec_o <= irq_vector_i;
  // Return followed by a divide, the slowest next instruction
  task automatic do_return();
    @(negedge mclk_i);
    return_done_o = 1'b1;
    @(negedge mclk_i);
    return_done_o = 1'b0;
    repeat (INSTR_CYC - 1) @(negedge mclk_i);
    instr_done_o = 1'b1;
    @(negedge mclk_i);
    instr_done_o = 1'b0;
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import vic_pkg::*;
  logic mclk, nrst_n, clk_en, sfr_wr, sfr_rd, bit_wr, bit_val, auto_ack;
  logic hit, req, ack, ret_done, instr;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, rdata;
  logic [3:0] fl, clr, spi_fl;
  logic [1:0] uart_fl, t2_fl, insv;
  logic [11:0] xfl, xen;
  logic [18:0] hp;
  logic [15:0] vec, last_vec;
  int fail_count, samples_checked;
  // ****
  // Clock, flag sources and instances
  // ****
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) fl <= fl & ~clr;
  vic_ctrl dut (.mclk_i(mclk), .nrst_i(nrst_n), .clk_en_i(clk_en), .sfr_addr_i(sfr_addr),
    .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .bit_wr_i(bit_wr),
    .bit_addr_i(bit_addr), .bit_val_i(bit_val), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .ext_irq_pin0_flag_i(fl[0]), .timer0_overflow_flag_i(fl[1]),
    .ext_irq_pin1_flag_i(fl[2]), .timer1_overflow_flag_i(fl[3]),
    .uart_rx_done_flag_i(uart_fl[0]), .uart_tx_done_flag_i(uart_fl[1]),
    .timer2_low_overflow_flag_i(t2_fl[0]), .timer2_high_overflow_flag_i(t2_fl[1]),
    .spi_transfer_done_flag_i(spi_fl[0]), .spi_write_collision_flag_i(spi_fl[1]),
    .spi_mode_fault_flag_i(spi_fl[2]), .spi_rx_overrun_flag_i(spi_fl[3]),
    .ext_src_flags_i(xfl), .ext_src_enable_i(xen), .src_high_prio_i(hp), .irq_ack_i(ack),
    .return_done_i(ret_done), .instr_done_i(instr), .irq_req_o(req), .irq_vector_o(vec),
    .flag_clear_o(clr), .in_service_o(insv));
  vic_core_model core (.mclk_i(mclk), .auto_ack_i(auto_ack), .irq_req_i(req),
    .irq_vector_i(vec), .irq_ack_o(ack), .return_done_o(ret_done), .instr_done_o(instr),
    .last_vec_o(last_vec));
  // ****
  // Access and check tasks
  // ****
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  task automatic bw(logic [7:0] a, logic v);
    @(negedge mclk);
    bit_addr = a;
    bit_val = v;
    bit_wr = 1'b1;
    @(negedge mclk);
    bit_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    // The hit output is combinational: let it settle before looking
    #1;
    chk("address hit", 16'(a == INT_EN_ADDR), 16'(hit));
    @(negedge mclk);
    sfr_rd = 1'b0;
    chk("register read", 16'(exp), 16'(rdata));
  endtask
  task automatic expect_req(int lim, logic [15:0] v);
    int n;
    n = 0;
    while (req !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk("request", 16'h0001, 16'(req));
    chk("vector", v, vec);
  endtask
  task automatic none(int c);
    repeat (c) begin
      @(negedge mclk);
      chk("no request", 16'h0000, 16'(req));
    end
  endtask
  task automatic serve(logic [15:0] v, logic [3:0] c, logic [1:0] l);
    expect_req(6, v);
    @(negedge mclk);
    chk("flag clear", 16'(c), 16'(clr));
    chk("in service", 16'(l), 16'(insv));
    chk("acked vector", v, last_vec);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    nrst_n = 1'b0;
    clk_en = 1'b1;
    {sfr_wr, sfr_rd, bit_wr, bit_val} = 4'h0;
    auto_ack = 1'b1;
    {sfr_addr, sfr_wdata, bit_addr} = 24'h000000;
    {fl, uart_fl, t2_fl, spi_fl} = 12'h000;
    {xfl, xen, hp} = 43'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (10) @(negedge mclk);
    nrst_n = 1'b1;
    chk("reset vector", VEC_RESET, vec);
    rd(INT_EN_ADDR, INT_EN_RESET);
    wr(INT_EN_ADDR, 8'h81);
    rd(INT_EN_ADDR, 8'h81);
    clk_en = 1'b0;
    wr(INT_EN_ADDR, 8'h00);
    clk_en = 1'b1;
    bw(8'ha9, 1'b1);
    rd(INT_EN_ADDR, 8'h83);
    rd(8'hb8, 8'h00);
    $display("test registers finished");
    wr(INT_EN_ADDR, 8'h01);
    fl[0] = 1'b1;
    none(4);
    bw(8'haf, 1'b1);
    serve(VEC_BASE, 4'h1, 2'b01);
    core.do_return();
    for (int s = 0; s < 7; s++) begin
      wr(INT_EN_ADDR, 8'h80);
      if (s < 4) fl[s] = 1'b1;
      uart_fl[s % 2] = (s == 4);
      t2_fl[s % 2] = (s == 5);
      spi_fl[s % 4] = (s == 6);
      none(2);
      wr(INT_EN_ADDR, 8'h80 | 8'(1 << s));
      serve(VEC_BASE + 16'(8 * s), (s < 4) ? 4'(1 << s) : 4'h0, 2'b01);
      {uart_fl, t2_fl, spi_fl} = 8'h00;
      core.do_return();
    end
    // Second pass drives the OR inputs that the first pass leaves idle
    for (int k = 0; k < 5; k++) begin
      wr(INT_EN_ADDR, 8'hf0);
      {uart_fl, t2_fl, spi_fl} = {k == 0, 2'b00, k == 1, k == 4, 1'b0, k == 3, k == 2};
      serve(VEC_BASE + 16'(8 * ((k < 2) ? k + 4 : 6)), 4'h0, 2'b01);
      {uart_fl, t2_fl, spi_fl} = 8'h00;
      core.do_return();
    end
    $display("test sources finished");
    wr(INT_EN_ADDR, 8'h8f);
    fl = 4'ha;
    expect_req(1, 16'h000b);
    serve(16'h000b, 4'h2, 2'b01);
    core.do_return();
    serve(16'h001b, 4'h8, 2'b01);
    core.do_return();
    $display("test arbitration finished");
    hp[3] = 1'b1;
    fl = 4'h1;
    serve(VEC_BASE, 4'h1, 2'b01);
    fl[3] = 1'b1;
    serve(16'h001b, 4'h8, 2'b11);
    hp[1] = 1'b1;
    fl[2:1] = 2'b11;
    none(4);
    fork
      core.do_return();
      none(9);
    join
    serve(16'h000b, 4'h2, 2'b11);
    fork
      core.do_return();
      none(12);
    join
    core.do_return();
    serve(16'h0013, 4'h4, 2'b01);
    core.do_return();
    $display("test priority finished");
    xfl[8] = 1'b1;
    none(3);
    xen[8] = 1'b1;
    serve(16'h007b, 4'h0, 2'b01);
    core.do_return();
    serve(16'h007b, 4'h0, 2'b01);
    xen[8] = 1'b0;
    core.do_return();
    none(4);
    $display("test read-only source finished");
    end_of_test();
  end
  // Run takes under 1500 cycles; this only cuts a hang short
  initial begin
    repeat (4000) @(posedge mclk);
    fail_count++;
    end_of_test();
  end
endmodule
